// [shared/vgs_pkg.sv]
// constants and carrier types for the voice path stage-two gain block
package vgs_pkg;

  // ==========================================================
  // register map
  localparam logic [7:0] VGS_TX_GAIN2_OFF   = 8'h26;  // transmit stage two
  localparam logic [7:0] VGS_RX_GAIN2_OFF   = 8'h27;  // receive stage two
  localparam logic [7:0] VGS_GAIN2_RESET    = 8'h00;  // both clear at reset
  localparam logic [7:0] VGS_UNMAPPED_READ  = 8'h00;  // answer off the map
  localparam int         VGS_SENSE_BIT      = 4;      // attenuate select
  localparam int         VGS_MAG_MSB        = 3;      // magnitude field top
  localparam int         VGS_MAG_LSB        = 0;      // magnitude field low

  // ==========================================================
  // gain range, in whole dB
  localparam int         VGS_DB_W           = 6;
  localparam logic [3:0] VGS_MAG_ZERO       = 4'h0;
  localparam logic [3:0] VGS_MAG_GAIN_CAP   = 4'hC;   // 12 dB and above
  localparam logic signed [5:0] VGS_DB_MAX_GAIN  = 6'sh0C;  // +12 dB
  localparam logic signed [5:0] VGS_DB_MAX_ATTEN = -6'sh0F; // -15 dB
  localparam logic signed [5:0] VGS_DB_UNITY     = 6'sh00;

  // ==========================================================
  // sample datapath
  localparam int          VGS_SAMPLE_W      = 16;
  localparam int          VGS_FRAC_BITS     = 12;     // gain factor q3.12
  localparam logic [15:0] VGS_FACTOR_UNITY  = 16'h1000;
  localparam logic signed [32:0] VGS_ROUND_HALF = 33'sh0_0000_0800;
  localparam logic signed [15:0] VGS_SAT_POS = 16'sh7FFF;
  localparam logic signed [15:0] VGS_SAT_NEG = -16'sh7FFF - 16'sh0001;

  // ==========================================================
  // types
  typedef logic signed [VGS_DB_W-1:0] vgs_db_t;

  typedef struct packed {
    logic [2:0] reserved;   // reads back zero
    logic       attenuate;  // 1 = codes attenuate
    logic [3:0] magnitude;  // 1 dB per step
  } vgs_stage_cfg_t;

  typedef struct packed {
    logic                           valid;
    logic signed [VGS_SAMPLE_W-1:0] data;
  } vgs_sample_t;

  typedef struct packed {
    logic       wrEn;
    logic       rdEn;
    logic [7:0] addr;
    logic [7:0] wrData;
  } vgs_cfg_req_t;

  typedef struct packed {
    vgs_stage_cfg_t txCfg;
    vgs_stage_cfg_t rxCfg;
    logic [7:0]     rdData;
  } vgs_bank_state_t;

endpackage

// [design/vgs_gain_decode.sv]
// turns a stage-two setting into a signed whole-dB gain
`timescale 1ns/100ps
module vgs_gain_decode
  import vgs_pkg::*;
(
  input  wire vgs_stage_cfg_t cfg,
  output vgs_db_t             gainDb
);

  // ==========================================================
  // decode: zero is unity, gain side saturates at the cap
  always_comb begin
    if (cfg.magnitude == VGS_MAG_ZERO) begin
      gainDb = VGS_DB_UNITY;
    end else if (cfg.attenuate) begin
      // one dB of loss per step, all ones is -15 dB
      gainDb = -vgs_db_t'({2'b00, cfg.magnitude});
    end else if (cfg.magnitude >= VGS_MAG_GAIN_CAP) begin
      gainDb = VGS_DB_MAX_GAIN;
    end else begin
      gainDb = vgs_db_t'({2'b00, cfg.magnitude});
    end
  end

endmodule

// [design/vgs_gain_mult.sv]
// scales one sample stream by a whole-dB gain, one cycle of latency
`timescale 1ns/100ps
module vgs_gain_mult
  import vgs_pkg::*;
#(
  parameter int SAMPLE_W = 16
)(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire vgs_db_t     gainDb,
  input  wire vgs_sample_t sampleIn,
  output vgs_sample_t      sampleOut
);

  // ==========================================================
  // elaboration check: carrier width is fixed by the package
  if (SAMPLE_W != VGS_SAMPLE_W) begin : g_badWidth
    $error("vgs_gain_mult: SAMPLE_W must match the sample carrier");
  end

  vgs_sample_t       mult_reg;   // registered output sample
  vgs_sample_t       mult_next;  // its next value
  logic [15:0]       factor;     // q3.12 linear gain
  logic signed [32:0] product;   // sample times factor
  logic signed [32:0] rounded;   // product plus half lsb
  logic signed [20:0] scaled;    // back to sample scale

  // ==========================================================
  // dB to linear factor, 10^(dB/20) in q3.12
  always_comb begin
    unique case (gainDb)
      -6'sd15: factor = 16'h02D8;
      -6'sd14: factor = 16'h0331;
      -6'sd13: factor = 16'h0395;
      -6'sd12: factor = 16'h0405;
      -6'sd11: factor = 16'h0482;
      -6'sd10: factor = 16'h050F;
      -6'sd9:  factor = 16'h05AD;
      -6'sd8:  factor = 16'h065F;
      -6'sd7:  factor = 16'h0726;
      -6'sd6:  factor = 16'h0805;
      -6'sd5:  factor = 16'h08FF;
      -6'sd4:  factor = 16'h0A18;
      -6'sd3:  factor = 16'h0B54;
      -6'sd2:  factor = 16'h0CB6;
      -6'sd1:  factor = 16'h0E43;
      6'sd1:   factor = 16'h11F4;
      6'sd2:   factor = 16'h1425;
      6'sd3:   factor = 16'h169A;
      6'sd4:   factor = 16'h195C;
      6'sd5:   factor = 16'h1C74;
      6'sd6:   factor = 16'h1FED;
      6'sd7:   factor = 16'h23D2;
      6'sd8:   factor = 16'h2831;
      6'sd9:   factor = 16'h2D18;
      6'sd10:  factor = 16'h3299;
      6'sd11:  factor = 16'h38C5;
      6'sd12:  factor = 16'h3FB2;
      // zero and any code the decoder never makes
      default: factor = VGS_FACTOR_UNITY;
    endcase
  end

  // ==========================================================
  // multiply, round to nearest, saturate instead of wrapping
  always_comb begin
    product   = 33'($signed(sampleIn.data) * $signed({1'b0, factor}));
    rounded   = product + VGS_ROUND_HALF;
    scaled    = rounded[32:VGS_FRAC_BITS];
    mult_next = mult_reg;
    mult_next.valid = sampleIn.valid;
    if (sampleIn.valid) begin
      if (scaled > 21'($signed(VGS_SAT_POS))) begin
        mult_next.data = VGS_SAT_POS;   // clip on gain overflow
      end else if (scaled < 21'($signed(VGS_SAT_NEG))) begin
        mult_next.data = VGS_SAT_NEG;
      end else begin
        mult_next.data = scaled[15:0];
      end
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mult_reg <= '0;
    end else begin
      mult_reg <= mult_next;
    end
  end

  assign sampleOut = mult_reg;

endmodule

// [design/vgs_gain_stage2.sv]
// stage-two coarse gain: two control registers and both voice paths
`timescale 1ns/100ps

module vgs_gain_stage2
  import vgs_pkg::*;
(
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire vgs_cfg_req_t cfgReq,
  output logic [7:0]        cfgRdData,
  input  wire vgs_sample_t  txIn,
  output vgs_sample_t       txOut,
  input  wire vgs_sample_t  rxIn,
  output vgs_sample_t       rxOut
);

  // ==========================================================
  // declarations
  vgs_bank_state_t bank_reg;   // both settings and read data
  vgs_bank_state_t bank_next;  // next value of the bank
  vgs_db_t         txGainDb;   // decoded transmit gain
  vgs_db_t         rxGainDb;   // decoded receive gain
  logic            hitTx;      // access aimed at transmit reg
  logic            hitRx;      // access aimed at receive reg

  // ==========================================================
  // address decode
  assign hitTx = (cfgReq.addr == VGS_TX_GAIN2_OFF);
  assign hitRx = (cfgReq.addr == VGS_RX_GAIN2_OFF);

  // ==========================================================
  // register bank next state
  // writes land in one cycle; a read answers on the next edge
  always_comb begin
    bank_next = bank_reg;
    if (cfgReq.wrEn && hitTx) begin
      bank_next.txCfg.attenuate = cfgReq.wrData[VGS_SENSE_BIT];
      bank_next.txCfg.magnitude =
        cfgReq.wrData[VGS_MAG_MSB:VGS_MAG_LSB];
    end
    if (cfgReq.wrEn && hitRx) begin
      bank_next.rxCfg.attenuate = cfgReq.wrData[VGS_SENSE_BIT];
      bank_next.rxCfg.magnitude =
        cfgReq.wrData[VGS_MAG_MSB:VGS_MAG_LSB];
    end
    // reserved bits cannot be written, so they always read zero
    bank_next.txCfg.reserved = 3'h0;
    bank_next.rxCfg.reserved = 3'h0;
    if (cfgReq.rdEn) begin
      if (hitTx) begin
        bank_next.rdData = bank_reg.txCfg;
      end else if (hitRx) begin
        bank_next.rdData = bank_reg.rxCfg;
      end else begin
        bank_next.rdData = VGS_UNMAPPED_READ;  // off the map
      end
    end
  end

  // ==========================================================
  // state register; both settings clear at reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bank_reg <= {VGS_GAIN2_RESET, VGS_GAIN2_RESET,
                   VGS_UNMAPPED_READ};
    end else begin
      bank_reg <= bank_next;
    end
  end

  assign cfgRdData = bank_reg.rdData;

  // ==========================================================
  // setting to dB, one decoder per path
  vgs_gain_decode u_txDecode (
    .cfg    (bank_reg.txCfg),
    .gainDb (txGainDb)
  );

  vgs_gain_decode u_rxDecode (
    .cfg    (bank_reg.rxCfg),
    .gainDb (rxGainDb)
  );

  // ==========================================================
  // sample scaling; a new setting applies from the next sample
  vgs_gain_mult #(
    .SAMPLE_W (VGS_SAMPLE_W)
  ) u_txMult (
    .clk       (clk),
    .rst_n     (rst_n),
    .gainDb    (txGainDb),
    .sampleIn  (txIn),
    .sampleOut (txOut)
  );

  vgs_gain_mult #(
    .SAMPLE_W (VGS_SAMPLE_W)
  ) u_rxMult (
    .clk       (clk),
    .rst_n     (rst_n),
    .gainDb    (rxGainDb),
    .sampleIn  (rxIn),
    .sampleOut (rxOut)
  );

  // ==========================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // transmit register write lands next cycle, reserved dropped
  chk_tx_write_lands: assert property (
    cfgReq.wrEn && hitTx |=>
      bank_reg.txCfg == {3'h0, $past(cfgReq.wrData[4:0])})
    else $error("transmit setting not stored");

  // receive register write lands next cycle, reserved dropped
  chk_rx_write_lands: assert property (
    cfgReq.wrEn && hitRx |=>
      bank_reg.rxCfg == {3'h0, $past(cfgReq.wrData[4:0])})
    else $error("receive setting not stored");

  // a read returns zero in bits 7:5 whatever was written
  chk_rd_reserved_zero: assert property (
    cfgReq.rdEn && (hitTx || hitRx) |=> cfgRdData[7:5] == 3'h0)
    else $error("reserved bits read nonzero");

  // readback of the transmit register shows the stored fields
  chk_rd_tx_value: assert property (
    cfgReq.rdEn && hitTx && !cfgReq.wrEn |=>
      cfgRdData == $past(bank_reg.txCfg))
    else $error("transmit readback wrong");

  // transmit gain side: step per code below the cap of twelve
  chk_tx_gain_steps: assert property (
    !bank_reg.txCfg.attenuate &&
      bank_reg.txCfg.magnitude < VGS_MAG_GAIN_CAP |->
      txGainDb == vgs_db_t'({2'b00, bank_reg.txCfg.magnitude}))
    else $error("transmit gain step wrong");

  // transmit magnitude zero is unity whatever the sense
  chk_tx_zero_unity: assert property (
    bank_reg.txCfg.magnitude == 4'h0 |-> txGainDb == VGS_DB_UNITY)
    else $error("transmit zero code not unity");

  // transmit attenuate all ones is 15 dB of loss
  chk_tx_atten_max: assert property (
    bank_reg.txCfg.attenuate && bank_reg.txCfg.magnitude == 4'hF |->
      txGainDb == -6'sd15)
    else $error("transmit full attenuation wrong");

  // transmit gain codes twelve and above saturate
  chk_tx_gain_sat: assert property (
    !bank_reg.txCfg.attenuate && bank_reg.txCfg.magnitude >= 4'hC |->
      txGainDb == 6'sd12)
    else $error("transmit gain not saturated");

  // receive gain side steps per code below the cap
  chk_rx_gain_steps: assert property (
    !bank_reg.rxCfg.attenuate && bank_reg.rxCfg.magnitude != 4'h0 &&
      bank_reg.rxCfg.magnitude[3:2] != 2'b11 |->
      rxGainDb == vgs_db_t'({2'b00, bank_reg.rxCfg.magnitude}))
    else $error("receive gain step wrong");

  // receive magnitude zero is unity whatever the sense
  chk_rx_zero_unity: assert property (
    bank_reg.rxCfg.magnitude == 4'h0 |-> rxGainDb == VGS_DB_UNITY)
    else $error("receive zero code not unity");

  // receive codes 11xx with gain sense give exactly 12 dB
  chk_rx_gain_sat: assert property (
    !bank_reg.rxCfg.attenuate && bank_reg.rxCfg.magnitude[3:2] == 2'b11
      |-> rxGainDb == 6'sd12)
    else $error("receive gain not saturated");

  // receive attenuate all ones is 15 dB of loss
  chk_rx_atten_max: assert property (
    bank_reg.rxCfg.attenuate && bank_reg.rxCfg.magnitude == 4'hF |->
      rxGainDb == -6'sd15)
    else $error("receive full attenuation wrong");

  // unity transmit gain passes the sample through unchanged
  chk_tx_unity_pass: assert property (
    txIn.valid && txGainDb == VGS_DB_UNITY |=>
      txOut.valid && txOut.data == $past(txIn.data))
    else $error("transmit unity changed the sample");

  // unity receive gain passes the sample through unchanged
  chk_rx_unity_pass: assert property (
    rxIn.valid && rxGainDb == VGS_DB_UNITY |=>
      rxOut.valid && rxOut.data == $past(rxIn.data))
    else $error("receive unity changed the sample");

  // transmit attenuation never grows a positive sample
  chk_tx_atten_shrinks: assert property (
    txIn.valid && txGainDb < 0 && txIn.data > 0 |=>
      txOut.data <= $past(txIn.data) && txOut.data >= 0)
    else $error("transmit attenuation grew the sample");

  // receive gain never shrinks a positive sample
  chk_rx_gain_grows: assert property (
    rxIn.valid && rxGainDb > 0 && rxIn.data > 0 |=>
      rxOut.data >= $past(rxIn.data))
    else $error("receive gain shrank the sample");

  // ==========================================================
  // further checks: readback, idle holding and output range

  // receive readback shows the stored fields
  chk_rd_rx_value: assert property (
    cfgReq.rdEn && hitRx && !cfgReq.wrEn |=>
      cfgRdData == $past(bank_reg.rxCfg))
    else $error("receive readback wrong");

  // reads off the map answer zero
  chk_rd_unmapped_zero: assert property (
    cfgReq.rdEn && !hitTx && !hitRx |=> cfgRdData == 8'h00)
    else $error("unmapped read nonzero");

  // read data stays put between reads, software may sample late
  chk_rd_data_holds: assert property (
    !cfgReq.rdEn |=> $stable(cfgRdData))
    else $error("read data moved without a read");

  // a write elsewhere leaves the transmit setting alone
  chk_tx_wr_kept: assert property (
    !(cfgReq.wrEn && hitTx) |=> $stable(bank_reg.txCfg))
    else $error("transmit setting changed without a write");

  // a write elsewhere leaves the receive setting alone
  chk_rx_wr_kept: assert property (
    !(cfgReq.wrEn && hitRx) |=> $stable(bank_reg.rxCfg))
    else $error("receive setting changed without a write");

  // each transmit attenuation step is one dB
  chk_tx_atten_steps: assert property (
    bank_reg.txCfg.attenuate && bank_reg.txCfg.magnitude != 4'h0 |->
      int'(txGainDb) == -int'(bank_reg.txCfg.magnitude))
    else $error("transmit attenuation step wrong");

  // each receive attenuation step is one dB
  chk_rx_atten_steps: assert property (
    bank_reg.rxCfg.attenuate && bank_reg.rxCfg.magnitude != 4'h0 |->
      int'(rxGainDb) == -int'(bank_reg.rxCfg.magnitude))
    else $error("receive attenuation step wrong");

  // decoded transmit gain never leaves the +12/-15 window
  chk_tx_gain_range: assert property (
    txGainDb <= VGS_DB_MAX_GAIN && txGainDb >= VGS_DB_MAX_ATTEN)
    else $error("transmit gain out of range");

  // decoded receive gain never leaves the +12/-15 window
  chk_rx_gain_range: assert property (
    rxGainDb <= VGS_DB_MAX_GAIN && rxGainDb >= VGS_DB_MAX_ATTEN)
    else $error("receive gain out of range");

  // every transmit sample comes out exactly one cycle later
  chk_tx_valid_next: assert property (
    txOut.valid == $past(txIn.valid))
    else $error("transmit valid not one cycle late");

  // every receive sample comes out exactly one cycle later
  chk_rx_valid_next: assert property (
    rxOut.valid == $past(rxIn.valid))
    else $error("receive valid not one cycle late");

  // idle transmit cycles hold the last scaled sample
  chk_tx_idle_hold: assert property (
    !txIn.valid |=> $stable(txOut.data))
    else $error("transmit data moved while idle");

  // idle receive cycles hold the last scaled sample
  chk_rx_idle_hold: assert property (
    !rxIn.valid |=> $stable(rxOut.data))
    else $error("receive data moved while idle");

  // transmit gain never shrinks a positive sample
  chk_tx_gain_grows: assert property (
    txIn.valid && txGainDb > 0 && txIn.data > 0 |=>
      txOut.data >= $past(txIn.data))
    else $error("transmit gain shrank the sample");

  // receive attenuation never grows a positive sample
  chk_rx_atten_shrinks: assert property (
    rxIn.valid && rxGainDb < 0 && rxIn.data > 0 |=>
      rxOut.data <= $past(rxIn.data) && rxOut.data >= 0)
    else $error("receive attenuation grew the sample");

  // saturation must clip, a wrapped product would flip the sign
  chk_tx_sign_kept: assert property (
    txIn.valid && txIn.data > 0 |=> txOut.data >= 0)
    else $error("transmit sample changed sign");

  // same on receive, where full gain drives negatives to the rail
  chk_rx_sign_kept: assert property (
    rxIn.valid && rxIn.data < 0 |=> rxOut.data <= 0)
    else $error("receive sample changed sign");

endmodule

// [test/testbench.sv]
// self-checking bench for the stage-two coarse gain block
`timescale 1ns/100ps
module testbench
  import vgs_pkg::*;
;
  // ==========================================================
  // bench signals
  localparam int TIMEOUT_CYC = 3000;  // whole run needs well under this

  logic         clk;        // 200 MHz bench clock
  logic         rst_n;      // async reset, active low
  vgs_cfg_req_t cfgReq;     // register port request
  logic [7:0]   cfgRdData;  // register read data
  vgs_sample_t  txIn;       // transmit samples in
  vgs_sample_t  txOut;      // transmit samples out
  vgs_sample_t  rxIn;       // receive samples in
  vgs_sample_t  rxOut;      // receive samples out
  int           error_cnt;  // mismatches seen
  int           checked;    // comparisons made
  int           cycles = 0; // clock cycles since start

  // ==========================================================
  // device under test
  vgs_gain_stage2 uut (
    .clk       (clk),
    .rst_n     (rst_n),
    .cfgReq    (cfgReq),
    .cfgRdData (cfgRdData),
    .txIn      (txIn),
    .txOut     (txOut),
    .rxIn      (rxIn),
    .rxOut     (rxOut)
  );

  // ==========================================================
  // clock and hang guard
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // a stuck handshake would otherwise run forever
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == TIMEOUT_CYC) begin
      error_cnt = error_cnt + 1;
      finish_test();
    end
  end

  // ==========================================================
  // helpers
  // compares one value and reports a mismatch at once
  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    checked = checked + 1;
    if (seen !== exp) begin
      error_cnt = error_cnt + 1;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one write pulse, request held across its taking edge
  task automatic cfg_write(input logic [7:0] addr, input logic [7:0] data);
    @(posedge clk);
    #1;
    cfgReq.wrEn   = 1'b1;
    cfgReq.addr   = addr;
    cfgReq.wrData = data;
    @(posedge clk);
    #1;
    cfgReq.wrEn   = 1'b0;
  endtask

  // one read pulse; data is sampled just after the taking edge
  task automatic cfg_read(input logic [7:0] addr, output logic [7:0] data);
    @(posedge clk);
    #1;
    cfgReq.rdEn = 1'b1;
    cfgReq.addr = addr;
    @(posedge clk);
    #1;
    cfgReq.rdEn = 1'b0;
    data        = cfgRdData;
  endtask

  // whole-dB gain a setting should give
  function automatic int exp_db(input logic [7:0] code);
    int mag;
    mag = int'(code[3:0]);
    if (mag == 0) return 0;
    if (code[4]) return -mag;
    return (mag > 12) ? 12 : mag;
  endfunction

  // scaled sample: q3.12 factor, round half up, saturate
  function automatic logic [15:0] exp_out(input int db, input int d);
    int     f;
    longint p;
    f = $rtoi(4096.0 * (10.0 ** (db / 20.0)) + 0.5);
    p = (longint'(d) * f + 2048) >>> 12;
    if (p > 32767) p = 32767;
    if (p < -32768) p = -32768;
    return p[15:0];
  endfunction

  // closing verdict, the only place the run ends
  task automatic finish_test();
    if (error_cnt == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ==========================================================
  // main sequence
  initial begin
    logic [7:0] rd;
    logic [7:0] txCode;
    logic [7:0] rxCode;
    int         rxSample;
    error_cnt = 0;
    checked   = 0;
    rst_n     = 1'b0;
    cfgReq    = '0;
    txIn      = '0;
    rxIn      = '0;
    repeat (12) @(posedge clk);
    #1;
    rst_n = 1'b1;
    // reset values of both registers
    cfg_read(VGS_TX_GAIN2_OFF, rd);
    check("txRegReset", {8'h00, rd}, 16'h0000);
    cfg_read(VGS_RX_GAIN2_OFF, rd);
    check("rxRegReset", {8'h00, rd}, 16'h0000);
    // every sense and magnitude code on both paths; rx gets the
    // opposite sense so the two registers are proven independent
    for (int i = 0; i < 32; i++) begin
      txCode = {3'b111, i[4:0]};
      rxCode = txCode ^ 8'h10;
      cfg_write(VGS_TX_GAIN2_OFF, txCode);
      cfg_write(VGS_RX_GAIN2_OFF, rxCode);
      cfg_read(VGS_TX_GAIN2_OFF, rd);
      check("txReg", {8'h00, rd}, {8'h00, txCode & 8'h1F});
      cfg_read(VGS_RX_GAIN2_OFF, rd);
      check("rxReg", {8'h00, rd}, {8'h00, rxCode & 8'h1F});
      // tx at an eighth of full scale; rx large and of alternating sign, so gain
      // drives it onto both rails and attenuation meets both signs
      rxSample = i[0] ? 16384 : -16384;
      @(posedge clk);
      #1;
      txIn = '{valid: 1'b1, data: 16'sh1000};
      rxIn = '{valid: 1'b1, data: 16'(rxSample)};
      @(posedge clk);
      #1;
      txIn.valid = 1'b0;
      rxIn.valid = 1'b0;
      check("txValid", {15'h0000, txOut.valid}, 16'h0001);
      check("txData", txOut.data,
            exp_out(exp_db(txCode), 4096));
      check("rxValid", {15'h0000, rxOut.valid}, 16'h0001);
      check("rxData", rxOut.data,
            exp_out(exp_db(rxCode), rxSample));
      @(posedge clk);
      #1;
      check("txIdle", {15'h0000, txOut.valid}, 16'h0000);
      check("rxIdle", {15'h0000, rxOut.valid}, 16'h0000);
    end
    // off-map write is dropped and off-map read answers zero
    cfg_write(8'h28, 8'h0A);
    cfg_read(8'h28, rd);
    check("unmappedRead", {8'h00, rd}, 16'h0000);
    cfg_read(VGS_TX_GAIN2_OFF, rd);
    check("txKept", {8'h00, rd}, 16'h001F);
    cfg_read(VGS_RX_GAIN2_OFF, rd);
    check("rxKept", {8'h00, rd}, 16'h000F);
    // second reset in mid-run clears both registers again
    @(posedge clk);
    #1;
    rst_n = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    rst_n = 1'b1;
    cfg_read(VGS_TX_GAIN2_OFF, rd);
    check("txRegReset2", {8'h00, rd}, 16'h0000);
    cfg_read(VGS_RX_GAIN2_OFF, rd);
    check("rxRegReset2", {8'h00, rd}, 16'h0000);
    finish_test();
  end
endmodule
